//--- inc/motor_map_pkg.sv
package motor_map_pkg;

   // Timing
   localparam int unsigned CLK_HZ = 32'h017D_7840;
   localparam int unsigned HOLD_S = 32'h0000_0004;
   localparam int unsigned HOLD_CYC = HOLD_S * CLK_HZ;
   localparam int unsigned READY_S = 32'h0000_0001;
   localparam int unsigned READY_CYC = READY_S * CLK_HZ;

   // Speed and pole arithmetic, frequency in tenths of a hertz
   localparam logic [7:0] POLE_CONST = 8'h78;
   localparam logic [7:0] FREQ_SCALE = 8'h0A;
   localparam logic [7:0] SLIP_DIV = POLE_CONST / FREQ_SCALE;
   localparam logic [7:0] POLE_AUTO = 8'h00;
   localparam logic [7:0] DEF_POLES = 8'h04;

   // Frequency ratio in Q16
   localparam int Q_SHIFT = 16;
   localparam logic [16:0] ONE = 17'h1_0000;
   localparam logic [16:0] HALF = ONE / 2;
   localparam logic [16:0] QUARTER = ONE / 4;
   localparam logic [16:0] RS_LOW = ONE / 50;
   localparam int GAIN_SHIFT = 8;
   localparam logic [8:0] GAIN_FULL = 9'h100;
   localparam logic [1:0] RAMP_NUM = 2'h2;
   localparam logic [1:0] RAMP_DEN = 2'h3;

   // Power factor in thousandths
   localparam logic [9:0] PF_ONE = 10'h3E8;
   localparam logic [19:0] PF_ONE_SQ = 20'(PF_ONE) * 20'(PF_ONE);

   typedef enum logic [2:0] {
      MEASURE_EVERY_RUN_MODE = 3'h0,
      NO_MEASURE_MODE = 3'h1,
      LINEAR_BOOST_MODE = 3'h2,
      MEASURE_ONCE_MODE = 3'h3,
      MEASURE_AT_POWERUP_MODE = 3'h4,
      SQUARE_LAW_BOOST_MODE = 3'h5,
      TAPERED_SLIP_BOOST_MODE = 3'h6
   } voltMode_t;

   typedef enum logic [1:0] {
      TUNE_NONE = 2'h0,
      TUNE_STATIONARY = 2'h1,
      TUNE_ROTATING = 2'h2
   } tuneSel_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_READY, ST_RS_TEST, ST_RUN, ST_TUNE_STAT,
      ST_TUNE_RAMP, ST_TUNE_HOLD, ST_TUNE_LS, ST_INHIBIT
   } ctrlState_t;

   typedef struct packed {
      logic [15:0] ratedFreq;
      logic [15:0] ratedSpeed;
      logic [15:0] ratedVolt;
      logic [15:0] ratedCur;
      logic [9:0] powerFactor;
      logic [7:0] poleSet;
      logic [15:0] lowFreqBoostSetting;
   } motorCfg_t;

   typedef struct packed {
      logic statorRes;
      logic transInd;
      logic deadtimeMax;
      logic deadtimeCur;
      logic statorInd;
      logic powerFactor;
   } measReq_t;

endpackage

//--- hdl/serial_divider.sv
`timescale 1ns/100ps
module serial_divider #(
   parameter int W = 32
) (
   input logic core_clk,
   input logic nrst,
   input logic [W-1:0] dividend,
   input logic [W-1:0] divisor,
   output logic [W-1:0] quotient
);
   localparam int CW = $clog2(W + 1);
   logic [W-1:0] rem;
   logic [W-1:0] quo;
   logic [CW-1:0] cnt;
   logic [W+1:0] trial;
   logic fits;

   // Restoring division, restarted after each result
   assign trial = {1'b0, rem, quo[W-1]} - {2'b00, divisor};
   assign fits = !trial[W+1];

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rem <= '0;
         quo <= '0;
         cnt <= '0;
         quotient <= '0;
      end else if (cnt == '0) begin
         rem <= '0;
         quo <= dividend;
         cnt <= CW'(W);
      end else begin
         rem <= fits ? trial[W-1:0] : {rem[W-2:0], quo[W-1]};
         quo <= {quo[W-2:0], fits};
         cnt <= cnt - 1'b1;
         if (cnt == CW'(1)) quotient <= {quo[W-2:0], fits};
      end
   end
endmodule

//--- hdl/open_loop_motor_map_control.sv
`timescale 1ns/100ps
// Behaviour
// [RQ1] Rated slip from frequency, poles, speed
// [RQ2] Zero or synchronous speed disables slip compensation
// [RQ3] Speed above synchronous gives negative slip
// [RQ4] Auto poles rounded to nearest even
// [RQ5] Displayed speed from output frequency and poles
// [RQ6] Tune code 1 stationary, 2 rotating
// [RQ7] Stationary test measures four quantities, no PF
// [RQ8] Rotating test ramps, holds, measures inductance
// [RQ9] Inhibit after tune until controlled disable
// [RQ10] Host disables via STO, enable or word
// [RQ11] Vector voltage linear then flat
// [RQ12] Resistance compensation full band, then taper
// [RQ13] Code 0 measures each run, 1 s guard
// [RQ14] Code 4 measures once per power-up
// [RQ15] Code 1 never measures
// [RQ16] Code 3 measures once, saves code 1; the code measures on every run while voltMode stays 3
// [RQ17] Boost modes linear or square, no resistance
// [RQ18] Code 6 linear with tapered slip limit
// [RQ19] Codes 2 and 5 add low-frequency boost
// [RQ20] Power factor gives active and magnetising current
// [RQ21] Profile endpoint is rated voltage at rated frequency
// [RQ22] Exact integer slip and pole arithmetic
module open_loop_motor_map_control #(
   parameter int unsigned HOLD_CYC = motor_map_pkg::HOLD_CYC,
   parameter int unsigned READY_CYC = motor_map_pkg::READY_CYC
) (
   input logic core_clk,
   input logic nrst,
   input motor_map_pkg::motorCfg_t cfg,
   input motor_map_pkg::voltMode_t voltMode,
   input motor_map_pkg::tuneSel_t tuneSel,
   input logic [15:0] outFreq,
   input logic safeTorqueIn,
   input logic runIn,
   input logic driveEnable,
   input logic ctrlWordEnable,
   input logic ctrlWordRun,
   input logic measDone,
   input logic measOk,
   input logic rampAtTarget,
   output logic [23:0] ratedSlip,
   output logic slipCompEn,
   output logic [7:0] poles,
   output logic [15:0] motorSpeed,
   output logic [15:0] voltOut,
   output logic [8:0] rsGain,
   output logic [15:0] activeCur,
   output logic [15:0] magCur,
   output logic [15:0] rsCompCur,
   output logic taperSlip,
   output motor_map_pkg::measReq_t measReq,
   output logic rampRun,
   output logic [15:0] rampTarget,
   output logic runActive,
   output logic inhibit,
   output logic nvSave,
   output motor_map_pkg::voltMode_t saveMode
);
   function automatic logic [9:0] isqrt(input logic [19:0] v);
      logic [9:0] r;
      logic [9:0] c;
      r = '0;
      for (int b = 9; b >= 0; b--) begin
         c = r | 10'(1 << b);
         if ({10'h0, c} * {10'h0, c} <= v) r = c;
      end
      return r;
   endfunction

   // Pin inputs: three stages, accepted when stages two and three agree
   logic [1:0] pinRaw;
   logic [1:0] s1;
   logic [1:0] s2;
   logic [1:0] s3;
   logic [1:0] pinF;
   assign pinRaw = {runIn, safeTorqueIn};
   for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            s1[i] <= 1'b0;
            s2[i] <= 1'b0;
            s3[i] <= 1'b0;
            pinF[i] <= 1'b0;
         end else begin
            s1[i] <= pinRaw[i];
            s2[i] <= s1[i];
            s3[i] <= s2[i];
            if (s2[i] == s3[i]) pinF[i] <= s3[i];
         end
      end
   end
   wire stoOk = pinF[0];
   wire runF = pinF[1];
   wire ctrlOk = stoOk && driveEnable && !(ctrlWordEnable && !ctrlWordRun);

   // Three dividers, one each: auto poles, frequency ratio, speed display
   logic [31:0] dvd [3];
   logic [31:0] dvs [3];
   logic [31:0] quo [3];
   assign dvd[0] = 32'(cfg.ratedFreq) * 32'(motor_map_pkg::SLIP_DIV)
      + 32'(cfg.ratedSpeed); // see [RQ4]
   assign dvs[0] = {15'h0, cfg.ratedSpeed, 1'b0};
   assign dvd[1] = {outFreq, 16'h0};
   assign dvs[1] = {16'h0, cfg.ratedFreq};
   assign dvd[2] = 32'(outFreq) * 32'(motor_map_pkg::SLIP_DIV); // see [RQ5]
   assign dvs[2] = {24'h0, poles};
   for (genvar i = 0; i < 3; i++) begin : g_div
      serial_divider #(.W(32)) u_div (
         .core_clk(core_clk),
         .nrst(nrst),
         .dividend(dvd[i]),
         .divisor(dvs[i]),
         .quotient(quo[i])
      );
   end

   // Poles and slip, exact integer forms
   wire polesAuto = cfg.poleSet == motor_map_pkg::POLE_AUTO;
   wire [7:0] autoPoles = (cfg.ratedSpeed == '0) ? motor_map_pkg::DEF_POLES
      : {quo[0][6:0], 1'b0}; // see [RQ4]
   wire [7:0] next_poles = polesAuto ? autoPoles : cfg.poleSet;
   wire [23:0] polesSpeed = 24'(poles) * 24'(cfg.ratedSpeed);
   wire [23:0] syncTerm = 24'(cfg.ratedFreq) * 24'(motor_map_pkg::SLIP_DIV);
   wire signed [24:0] slipRaw = $signed({1'b0, syncTerm})
      - $signed({1'b0, polesSpeed}); // see [RQ1] [RQ3] [RQ22]
   wire signed [24:0] slipDiv = $signed(25'(motor_map_pkg::SLIP_DIV));
   wire signed [24:0] slipTenths = slipRaw / slipDiv;
   wire next_slipEn = cfg.ratedSpeed != '0 && slipRaw != '0; // see [RQ2]

   // Voltage profile
   wire isSquare = voltMode == motor_map_pkg::SQUARE_LAW_BOOST_MODE;
   wire isBoost = voltMode == motor_map_pkg::LINEAR_BOOST_MODE || isSquare;
   wire isTaper = voltMode == motor_map_pkg::TAPERED_SLIP_BOOST_MODE;
   wire isVector = !isBoost && !isTaper && voltMode != 3'h7;
   wire fAbove = outFreq >= cfg.ratedFreq;
   wire [16:0] ratio = fAbove ? motor_map_pkg::ONE
      : {1'b0, quo[1][15:0]}; // see [RQ11]
   wire [32:0] linProd = 33'(cfg.ratedVolt) * 33'(ratio); // see [RQ21]
   wire [15:0] linV = linProd[31:16];
   wire [32:0] sqProd = 33'(linV) * 33'(ratio);
   wire [15:0] shapeV = isSquare ? sqProd[31:16] : linV; // see [RQ17]
   wire [16:0] boostSpan = motor_map_pkg::HALF - ratio;
   wire [32:0] boostProd = 33'(cfg.lowFreqBoostSetting) * 33'(boostSpan);
   wire boostOn = isBoost && ratio < motor_map_pkg::HALF;
   wire [15:0] boostV = boostOn ? boostProd[30:15] : 16'h0000; // see [RQ19]
   wire [16:0] sumV = {1'b0, shapeV} + {1'b0, boostV};
   wire [15:0] next_volt = sumV[16] ? 16'hFFFF : sumV[15:0];

   // Stator resistance compensation gain
   wire [8:0] taperGain = 9'((26'(boostSpan) * 26'(motor_map_pkg::GAIN_FULL))
      / 26'(motor_map_pkg::QUARTER));
   wire [8:0] next_gain = (!isVector || ratio < motor_map_pkg::RS_LOW) ? 9'h000
      : (ratio <= motor_map_pkg::QUARTER) ? motor_map_pkg::GAIN_FULL
      : (ratio < motor_map_pkg::HALF) ? taperGain : 9'h000; // see [RQ12]

   // Rated currents from power factor
   wire [19:0] pfSq = 20'(cfg.powerFactor) * 20'(cfg.powerFactor);
   wire [9:0] sinPhi = isqrt(motor_map_pkg::PF_ONE_SQ - pfSq);
   wire [25:0] actProd = 26'(cfg.ratedCur) * 26'(cfg.powerFactor);
   wire [25:0] magProd = 26'(cfg.ratedCur) * 26'(sinPhi);
   wire [25:0] pfDiv = 26'(motor_map_pkg::PF_ONE);
   wire [24:0] compProd = 25'(magCur) * 25'(rsGain);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         poles <= 8'h04;
         ratedSlip <= '0;
         slipCompEn <= 1'b0;
         motorSpeed <= '0;
      end else begin
         poles <= next_poles;
         ratedSlip <= slipTenths[23:0];
         slipCompEn <= next_slipEn;
         motorSpeed <= quo[2][15:0]; // see [RQ5]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         voltOut <= '0;
         rsGain <= '0;
         taperSlip <= 1'b0;
         rampTarget <= '0;
      end else begin
         voltOut <= next_volt;
         rsGain <= next_gain;
         taperSlip <= isTaper; // see [RQ18]
         rampTarget <= 16'((18'(cfg.ratedFreq) * 18'(motor_map_pkg::RAMP_NUM))
            / 18'(motor_map_pkg::RAMP_DEN)); // see [RQ8]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         activeCur <= '0;
         magCur <= '0;
         rsCompCur <= '0;
      end else begin
         activeCur <= 16'(actProd / pfDiv); // see [RQ20]
         magCur <= 16'(magProd / pfDiv);
         rsCompCur <= 16'(compProd >> motor_map_pkg::GAIN_SHIFT);
      end
   end

   // Run, measurement and autotune sequencing
   motor_map_pkg::ctrlState_t state;
   motor_map_pkg::ctrlState_t nextState;
   motor_map_pkg::measReq_t nextReq;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic rotating;
   logic puMeasured;
   wire readyExpired = cnt >= READY_CYC;
   wire needRs =
      (voltMode == motor_map_pkg::MEASURE_EVERY_RUN_MODE && readyExpired)
      || (voltMode == motor_map_pkg::MEASURE_AT_POWERUP_MODE && !puMeasured)
      || voltMode == motor_map_pkg::MEASURE_ONCE_MODE;
   wire saveNow = state == motor_map_pkg::ST_RS_TEST && measDone && measOk
      && voltMode == motor_map_pkg::MEASURE_ONCE_MODE;

   always_comb begin
      nextState = state;
      next_cnt = '0;
      if (!ctrlOk) begin
         nextState = motor_map_pkg::ST_IDLE; // see [RQ10]
      end else begin
         unique case (state)
            motor_map_pkg::ST_IDLE: begin
               nextState = motor_map_pkg::ST_READY;
            end
            motor_map_pkg::ST_READY: begin
               next_cnt = readyExpired ? cnt : cnt + 1'b1;
               if (runF && tuneSel != motor_map_pkg::TUNE_NONE) begin
                  nextState = motor_map_pkg::ST_TUNE_STAT; // see [RQ6]
               end else if (runF) begin
                  nextState = needRs ? motor_map_pkg::ST_RS_TEST
                     : motor_map_pkg::ST_RUN; // see [RQ13] [RQ14] [RQ15]
               end
            end
            motor_map_pkg::ST_RS_TEST: begin
               if (measDone) nextState = motor_map_pkg::ST_RUN;
            end
            motor_map_pkg::ST_RUN: begin
               if (!runF) nextState = motor_map_pkg::ST_READY;
            end
            motor_map_pkg::ST_TUNE_STAT: begin
               if (measDone) begin
                  nextState = rotating ? motor_map_pkg::ST_TUNE_RAMP
                     : motor_map_pkg::ST_INHIBIT; // see [RQ8] [RQ9]
               end
            end
            motor_map_pkg::ST_TUNE_RAMP: begin
               if (rampAtTarget) nextState = motor_map_pkg::ST_TUNE_HOLD;
            end
            motor_map_pkg::ST_TUNE_HOLD: begin
               next_cnt = cnt + 1'b1;
               if (cnt == HOLD_CYC - 1) begin
                  nextState = motor_map_pkg::ST_TUNE_LS; // see [RQ8]
               end
            end
            motor_map_pkg::ST_TUNE_LS: begin
               if (measDone) nextState = motor_map_pkg::ST_INHIBIT;
            end
            motor_map_pkg::ST_INHIBIT: begin
               nextState = motor_map_pkg::ST_INHIBIT; // see [RQ9]
            end
            default: begin
               nextState = motor_map_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign nextReq.statorRes = nextState == motor_map_pkg::ST_RS_TEST
      || nextState == motor_map_pkg::ST_TUNE_STAT; // see [RQ7]
   assign nextReq.transInd = nextState == motor_map_pkg::ST_TUNE_STAT;
   assign nextReq.deadtimeMax = nextState == motor_map_pkg::ST_TUNE_STAT;
   assign nextReq.deadtimeCur = nextState == motor_map_pkg::ST_TUNE_STAT;
   assign nextReq.statorInd = nextState == motor_map_pkg::ST_TUNE_LS;
   assign nextReq.powerFactor = nextState == motor_map_pkg::ST_TUNE_LS;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= motor_map_pkg::ST_IDLE;
         cnt <= '0;
         measReq <= '0;
      end else begin
         state <= nextState;
         cnt <= next_cnt;
         measReq <= nextReq;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rampRun <= 1'b0;
         runActive <= 1'b0;
         inhibit <= 1'b0;
         rotating <= 1'b0;
      end else begin
         rampRun <= nextState == motor_map_pkg::ST_TUNE_RAMP
            || nextState == motor_map_pkg::ST_TUNE_HOLD;
         runActive <= nextState == motor_map_pkg::ST_RUN;
         inhibit <= nextState == motor_map_pkg::ST_INHIBIT;
         if (state == motor_map_pkg::ST_READY) begin
            rotating <= tuneSel == motor_map_pkg::TUNE_ROTATING;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         puMeasured <= 1'b0;
         nvSave <= 1'b0;
         saveMode <= motor_map_pkg::MEASURE_ONCE_MODE;
      end else begin
         if (state == motor_map_pkg::ST_RS_TEST && measDone) begin
            puMeasured <= 1'b1; // see [RQ14]
         end
         nvSave <= saveNow; // see [RQ16]
         if (saveNow) saveMode <= motor_map_pkg::NO_MEASURE_MODE;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   slip_disable_a: assert property ( // see [RQ2]
      cfg.ratedSpeed == '0 |=> !slipCompEn)
      else $error("Slip compensation on with zero rated speed");
   neg_slip_a: assert property ( // see [RQ3]
      !polesAuto && $stable(cfg) && $stable(poles)
      && polesSpeed >= syncTerm + 24'(motor_map_pkg::SLIP_DIV)
      |=> ratedSlip[23])
      else $error("Slip not negative above synchronous speed");
   poles_even_a: assert property ( // see [RQ4]
      polesAuto[*2] |=> !poles[0])
      else $error("Automatic pole count is odd");
   volt_flat_a: assert property ( // see [RQ11]
      (isVector || isBoost) && fAbove
      |=> voltOut == $past(cfg.ratedVolt))
      else $error("Voltage not rated above rated frequency");
   boost_no_rs_a: assert property ( // see [RQ17]
      isBoost |=> rsGain == '0)
      else $error("Resistance compensation in boost mode");
   tune_start_a: assert property ( // see [RQ6]
      state == motor_map_pkg::ST_READY && runF && ctrlOk
      && tuneSel == motor_map_pkg::TUNE_STATIONARY
      |=> state == motor_map_pkg::ST_TUNE_STAT ##0 measReq.transInd)
      else $error("Stationary tune did not start");
   inhibit_hold_a: assert property ( // see [RQ9]
      state == motor_map_pkg::ST_INHIBIT && ctrlOk
      |=> inhibit && !runActive)
      else $error("Inhibit left without controlled disable");
   hold_len_a: assert property ( // see [RQ8]
      state == motor_map_pkg::ST_TUNE_LS
      && $past(state) == motor_map_pkg::ST_TUNE_HOLD
      |-> $past(cnt) == HOLD_CYC - 1)
      else $error("Rotating hold length wrong");
   stat_no_pf_a: assert property ( // see [RQ7]
      state == motor_map_pkg::ST_TUNE_STAT
      |-> !measReq.powerFactor && measReq.statorRes)
      else $error("Stationary tune requests wrong quantities");
   guard_skip_a: assert property ( // see [RQ13]
      state == motor_map_pkg::ST_READY && runF && ctrlOk && !readyExpired
      && tuneSel == motor_map_pkg::TUNE_NONE
      && voltMode == motor_map_pkg::MEASURE_EVERY_RUN_MODE
      |=> state == motor_map_pkg::ST_RUN)
      else $error("Resistance measured inside ready guard");
   no_measure_a: assert property ( // see [RQ15]
      voltMode == motor_map_pkg::NO_MEASURE_MODE
      |-> state != motor_map_pkg::ST_RS_TEST
      || $past(voltMode) != motor_map_pkg::NO_MEASURE_MODE)
      else $error("Measurement in no-measure mode");
   save_mode_a: assert property ( // see [RQ16]
      nvSave |-> saveMode == motor_map_pkg::NO_MEASURE_MODE
      && $past(state) == motor_map_pkg::ST_RS_TEST)
      else $error("Mode save without successful measurement");
endmodule

//--- bench/motor_partner.sv
`timescale 1ns/100ps
// Measurement engine and motor ramp as seen from the control block
module motor_partner (
   input logic core_clk,
   input logic nrst,
   input motor_map_pkg::measReq_t measReq,
   input logic rampRun,
   input logic [7:0] dly,
   input logic failNext,
   output logic measDone,
   output logic measOk,
   output logic rampAtTarget
);
   logic [7:0] cnt;
   logic [7:0] rampCnt;
   logic okBit;

   // Result flag is only meaningful beside done, so it moves otherwise
   assign measOk = measDone ? okBit : cnt[0];

   // One answer per request, dly + 1 cycles after it appears
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 8'h00;
         measDone <= 1'b0;
         okBit <= 1'b0;
      end else begin
         measDone <= (measReq != '0) && (cnt == dly) && !measDone;
         okBit <= !failNext;
         cnt <= (measReq == '0 || measDone) ? 8'h00 : cnt + 8'h01;
      end
   end

   // Ramp reaches its target dly + 1 cycles after it starts
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rampCnt <= 8'h00;
         rampAtTarget <= 1'b0;
      end else begin
         rampCnt <= rampRun ? rampCnt + 8'h01 : 8'h00;
         rampAtTarget <= rampRun && (rampCnt >= dly);
      end
   end
endmodule

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
   typedef struct {
      int sel;
      logic [23:0] val;
   } note_t;
   localparam int unsigned HOLD = 20;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   motor_map_pkg::motorCfg_t cfg;
   motor_map_pkg::voltMode_t voltMode;
   motor_map_pkg::tuneSel_t tuneSel;
   logic [15:0] outFreq;
   logic safeTorqueIn, runIn, driveEnable, ctrlWordEnable, ctrlWordRun;
   logic measDone, measOk, rampAtTarget, failNext;
   logic [7:0] dly;
   logic [23:0] ratedSlip;
   logic slipCompEn, taperSlip, rampRun, runActive, inhibit, nvSave;
   logic [7:0] poles;
   logic [15:0] motorSpeed, voltOut, activeCur, magCur, rampTarget, rsCompCur;
   logic [8:0] rsGain;
   motor_map_pkg::measReq_t measReq;
   motor_map_pkg::voltMode_t saveMode;
   note_t noteQ[$];
   note_t cur;
   logic [23:0] got;
   int errCount = 0;
   int numChecks = 0;
   int seed = 37014;
   int k;
   event sampleEv;

   always #20 core_clk = ~core_clk;

   open_loop_motor_map_control #(.HOLD_CYC(HOLD), .READY_CYC(10)) dut (
      .core_clk(core_clk), .nrst(nrst), .cfg(cfg), .voltMode(voltMode),
      .tuneSel(tuneSel), .outFreq(outFreq), .safeTorqueIn(safeTorqueIn),
      .runIn(runIn), .driveEnable(driveEnable),
      .ctrlWordEnable(ctrlWordEnable), .ctrlWordRun(ctrlWordRun),
      .measDone(measDone), .measOk(measOk), .rampAtTarget(rampAtTarget),
      .ratedSlip(ratedSlip), .slipCompEn(slipCompEn), .poles(poles),
      .motorSpeed(motorSpeed), .voltOut(voltOut), .rsGain(rsGain),
      .activeCur(activeCur), .magCur(magCur), .rsCompCur(rsCompCur),
      .taperSlip(taperSlip), .measReq(measReq), .rampRun(rampRun),
      .rampTarget(rampTarget), .runActive(runActive), .inhibit(inhibit),
      .nvSave(nvSave), .saveMode(saveMode));

   motor_partner partner (
      .core_clk(core_clk), .nrst(nrst), .measReq(measReq),
      .rampRun(rampRun), .dly(dly), .failNext(failNext),
      .measDone(measDone), .measOk(measOk), .rampAtTarget(rampAtTarget));

   // Output selector shared by the monitor and the bounded waits
   function automatic logic [23:0] pickOut(input int sel);
      case (sel)
         0: return ratedSlip;
         1: return 24'(slipCompEn);
         2: return 24'(poles);
         3: return 24'(motorSpeed);
         4: return 24'(voltOut);
         5: return 24'(rsGain);
         6: return 24'(activeCur);
         7: return 24'(magCur);
         8: return 24'(measReq);
         9: return 24'(runActive);
         10: return 24'(inhibit);
         11: return 24'(nvSave);
         12: return 24'(saveMode);
         13: return 24'(rampRun);
         14: return 24'(rampTarget);
         15: return 24'(taperSlip);
         17: return 24'(rsCompCur);
         default: return 24'(rampAtTarget);
      endcase
   endfunction

   task automatic printVerdict();
      if (errCount == 0 && numChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic note(input int sel, input logic [23:0] val);
      noteQ.push_back('{sel, val});
      -> sampleEv;
   endtask

   always @(sampleEv) begin
      while (noteQ.size() > 0) begin
         cur = noteQ.pop_front();
         got = pickOut(cur.sel);
         numChecks++;
         if (got !== cur.val) begin
            $display("mismatch at %0t: got %h expected %h", $time, got,
               cur.val);
            errCount++;
         end
      end
   end

   task automatic waitSig(input int sel, input logic [23:0] val,
      input int lim);
      int i;
      i = 0;
      while (pickOut(sel) !== val && i < lim) begin
         @(negedge core_clk);
         i++;
      end
      numChecks++;
      if (pickOut(sel) !== val) begin
         $display("mismatch at %0t: got %h expected %h", $time,
            pickOut(sel), val);
         errCount++;
         printVerdict();
      end
   endtask

   task automatic apply(input logic [15:0] spd, input logic [7:0] pol,
      input motor_map_pkg::voltMode_t m, input logic [15:0] f);
      cfg.ratedSpeed = spd;
      cfg.poleSet = pol;
      voltMode = m;
      outFreq = f;
      repeat (140) @(negedge core_clk);
   endtask

   task automatic tune(input int m);
      dly = (m == 1) ? 8'h0C : 8'h02;
      tuneSel = (m == 2) ? motor_map_pkg::TUNE_ROTATING
                         : motor_map_pkg::TUNE_STATIONARY;
      cfg.ratedFreq = (m == 2) ? 16'h0258 : 16'h01F4;
      runIn = 1'b1;
      waitSig(8, 24'h00_003C, 30);
      if (m == 2) begin
         waitSig(13, 24'h00_0001, 40);
         note(14, 24'h00_0190);
         waitSig(16, 24'h00_0001, 40);
         repeat (HOLD - 2) @(negedge core_clk);
         note(8, 24'h00_0000);
         waitSig(8, 24'h00_0003, 8);
      end
      waitSig(10, 24'h00_0001, 40);
      repeat (6) @(negedge core_clk);
      note(10, 24'h00_0001);
      case (m)
         0: safeTorqueIn = 1'b0;
         1: driveEnable = 1'b0;
         default: ctrlWordEnable = 1'b1;
      endcase
      waitSig(10, 24'h00_0000, 20);
      safeTorqueIn = 1'b1;
      driveEnable = 1'b1;
      ctrlWordEnable = 1'b0;
      tuneSel = motor_map_pkg::TUNE_NONE;
      waitSig(9, 24'h00_0001, 30);
      note(8, 24'h00_0000);
      runIn = 1'b0;
      repeat (12) @(negedge core_clk);
   endtask

   task automatic runOnce(input logic meas, input int gap);
      runIn = 1'b0;
      repeat (gap) @(negedge core_clk);
      runIn = 1'b1;
      if (meas) begin
         waitSig(8, 24'h00_0020, 20);
      end else begin
         repeat (10) @(negedge core_clk);
         note(8, 24'h00_0000);
         waitSig(9, 24'h00_0001, 20);
      end
   endtask

   initial begin
      cfg = '{16'h01F4, 16'h05A0, 16'h0190, 16'h03E8, 10'h320, 8'h04,
         16'h0032};
      voltMode = motor_map_pkg::NO_MEASURE_MODE;
      tuneSel = motor_map_pkg::TUNE_NONE;
      outFreq = 16'h00FA;
      {safeTorqueIn, runIn, driveEnable} = 3'b101;
      {ctrlWordEnable, ctrlWordRun, failNext} = 3'b000;
      dly = 8'h02;
      repeat (4) @(negedge core_clk);
      nrst = 1'b1;
      apply(16'h05A0, 8'h04, motor_map_pkg::NO_MEASURE_MODE, 16'h00FA);
      note(0, 24'h00_0014);
      note(1, 24'h00_0001);
      note(3, 24'h00_02EE);
      note(4, 24'h00_00C8);
      note(6, 24'h00_0320);
      note(7, 24'h00_0258);
      apply(16'h05DC, 8'h04, motor_map_pkg::NO_MEASURE_MODE, 16'h00FA);
      note(1, 24'h00_0000);
      apply(16'h0000, 8'h04, motor_map_pkg::NO_MEASURE_MODE, 16'h00FA);
      note(1, 24'h00_0000);
      apply(16'h0618, 8'h04, motor_map_pkg::NO_MEASURE_MODE, 16'h00FA);
      note(0, 24'hFF_FFEC);
      apply(16'h0B54, 8'h00, motor_map_pkg::NO_MEASURE_MODE, 16'h00FA);
      note(2, 24'h00_0002);
      note(3, 24'h00_05DC);
      apply(16'h03C0, 8'h00, motor_map_pkg::NO_MEASURE_MODE, 16'h00FA);
      note(2, 24'h00_0006);
      note(3, 24'h00_01F4);
      apply(16'h05A0, 8'h00, motor_map_pkg::NO_MEASURE_MODE, 16'h0258);
      note(2, 24'h00_0004);
      note(4, 24'h00_0190);
      note(5, 24'h00_0000);
      apply(16'h05A0, 8'h04, motor_map_pkg::NO_MEASURE_MODE, 16'h0064);
      note(5, 24'h00_0100);
      note(17, 24'h00_0258);
      apply(16'h05A0, 8'h04, motor_map_pkg::SQUARE_LAW_BOOST_MODE, 16'h00FA);
      note(4, 24'h00_0064);
      note(5, 24'h00_0000);
      apply(16'h05A0, 8'h04, motor_map_pkg::LINEAR_BOOST_MODE, 16'h0000);
      note(4, 24'h00_0032);
      apply(16'h05A0, 8'h04, motor_map_pkg::SQUARE_LAW_BOOST_MODE, 16'h0000);
      note(4, 24'h00_0032);
      apply(16'h05A0, 8'h04, motor_map_pkg::TAPERED_SLIP_BOOST_MODE,
         16'h00FA);
      note(4, 24'h00_00C8);
      note(15, 24'h00_0001);
      for (int r = 0; r < 4; r++) begin
         k = $unsigned($random(seed)) % 4;
         apply(16'h05A0, 8'h04, motor_map_pkg::NO_MEASURE_MODE, 16'(125 * k));
         note(4, 24'(100 * k));
      end
      for (int m = 0; m < 3; m++) begin
         tune(m);
      end
      cfg.ratedFreq = 16'h01F4;
      voltMode = motor_map_pkg::MEASURE_ONCE_MODE;
      failNext = 1'b1;
      runOnce(1'b1, 20);
      repeat (8) @(negedge core_clk);
      note(12, 24'h00_0003);
      failNext = 1'b0;
      runOnce(1'b1, 20);
      waitSig(11, 24'h00_0001, 20);
      note(12, 24'h00_0001);
      @(negedge core_clk);
      note(11, 24'h00_0000);
      voltMode = motor_map_pkg::MEASURE_EVERY_RUN_MODE;
      runOnce(1'b1, 30);
      waitSig(9, 24'h00_0001, 40);
      runOnce(1'b0, 2);
      nrst = 1'b0;
      repeat (3) @(negedge core_clk);
      nrst = 1'b1;
      voltMode = motor_map_pkg::MEASURE_AT_POWERUP_MODE;
      runOnce(1'b1, 8);
      waitSig(9, 24'h00_0001, 40);
      runOnce(1'b0, 30);
      @(negedge core_clk);
      printVerdict();
   end
endmodule
